// [pwm_cfg.svh]
// constants for the dual-slope 16-bit pwm block
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define OFF_CTRL      12'h000
`define OFF_CMP_A     12'h004
`define OFF_CMP_B     12'h008
`define OFF_CAP_TOP   12'h00c
`define OFF_STATUS    12'h010
`define OFF_COUNT     12'h014
`define OFF_PRESCALE  12'h018
`define CTRL_MODE_LSB 0
`define CTRL_CMA_LSB  4
`define CTRL_CMB_LSB  6
`define CTRL_DIRA_BIT 8
`define CTRL_DIRB_BIT 9
`define ST_OVF_BIT    0
`define ST_CMPA_BIT   1
`define ST_CMPB_BIT   2
`define ST_CAP_BIT    3
`define ST_DOWN_BIT   4
`define TOP_8BIT      16'h00ff
`define TOP_9BIT      16'h01ff
`define TOP_10BIT     16'h03ff
`define BOTTOM        16'h0000
`define PS_DIV8       10'h007
`define PS_DIV64      10'h03f
`define PS_DIV256     10'h0ff
`define PS_DIV1024    10'h3ff
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// [pwm_pkg.sv]
// types for the dual-slope 16-bit pwm block
package pwm_pkg;
  typedef enum logic [3:0] {
    WM_STOP   = 4'h0,
    WM_PC8    = 4'h1,
    WM_PC9    = 4'h2,
    WM_PC10   = 4'h3,
    WM_PFC_CT = 4'h8,
    WM_PFC_A  = 4'h9,
    WM_PC_CT  = 4'ha,
    WM_PC_A   = 4'hb
  } waveform_mode_t;

  typedef enum logic [1:0] {
    CM_OFF    = 2'h0,
    CM_TOGGLE = 2'h1,
    CM_NONINV = 2'h2,
    CM_INV    = 2'h3
  } compare_output_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;

  typedef struct packed {
    logic level;
    logic enable;
  } pin_out_t;
endpackage

// [compare_channel.sv]
// one compare channel: buffer, active value, match flag, output level
`include "pwm_cfg.svh"
module compare_channel
  import pwm_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic                 buf_wr,
  input  wire logic [15:0]          buf_wdata,
  input  wire logic [15:0]          res_mask,
  input  wire logic                 load,
  input  wire logic                 tick,
  input  wire logic [15:0]          count,
  input  wire logic                 down,
  input  wire pwm_pkg::compare_output_mode_t mode,
  input  wire logic                 toggle_ok,
  output logic [15:0]               active,
  output logic                      match,
  output logic                      level
);
  import pwm_pkg::*;
  logic [15:0] buf_q;
  logic [15:0] active_q;
  logic        level_q;
  logic        level_d;

  assign active = active_q;
  assign match  = tick && (count == active_q);

  always_comb begin
    level_d = level_q;
    if (match) begin
      case (mode)
        CM_NONINV: level_d = down;
        CM_INV:    level_d = ~down;
        CM_TOGGLE: level_d = toggle_ok ? ~level_q : level_q;
        default:   level_d = level_q;
      endcase
    end
  end
  assign level = level_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      buf_q    <= `BOTTOM;
      active_q <= `BOTTOM;
      level_q  <= 1'b0;
    end else begin
      if (buf_wr)
        buf_q <= buf_wdata & res_mask;
      if (load)
        active_q <= buf_q;
      level_q <= level_d;
    end
  end
endmodule

// [dual_slope_pwm_16bit.sv]
// dual-slope 16-bit pwm timer with an axi4-lite register slave
// Behaviour
// - modes 1,2,3,10,11 run phase correct dual-slope counting
// - count up from zero to top, then down to zero, forever
// - top is 0xff/0x1ff/0x3ff, capture/top register, or compare a
// - counter holds top for one timer clock before counting down
// - non-inverting clears on up-match, sets on down-match; inverting opposite
// - output mode two is non-inverted pwm, three is inverted
// - output reaches the pin only while its direction bit selects output
// - phase correct mode sets overflow flag at bottom
// - phase correct loads compares at top, setting compare-a or capture flag
// - fixed top masks compare writes above the resolution to zero
// - phase correct: compare bottom gives constant low, top constant high
// - mode 11 with output mode 1 toggles output a on match
// - modes 8 and 9 run phase and frequency correct, top capture or a
// - phase and frequency correct loads compares at bottom, sets overflow
// - phase and frequency correct sets compare-a or capture flag at top
// - each channel sets its own compare flag on a match
// - mode 9 with output mode 1 toggles output a on match
// - phase and frequency correct: bottom gives low, top gives high
// - counter advances only on prescaler enables of 1,8,64,256,1024
// - capture/top register is unbuffered, writes act at once
// - toggle setting drives only output a, output b stays port
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "pwm_cfg.svh"
module dual_slope_pwm_16bit
  import pwm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             compare_output_a,
  output logic             compare_output_a_en,
  output logic             compare_output_b,
  output logic             compare_output_b_en
);
  import pwm_pkg::*;

  // ==========================================================
  // register bus
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire aw_take  = s_axi_awvalid && !aw_have_q && !bvalid_q;
  wire w_take   = s_axi_wvalid && !w_have_q && !bvalid_q;
  wire wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  wire ar_take  = s_axi_arvalid && !rvalid_q;
  wr_req_t wr;
  assign wr = '{addr: awaddr_q, data: wdata_q, strb: wstrb_q};

  wire wr_full  = wr_fire && (wr.strb[1:0] == 2'h3);
  wire wr_ctrl  = wr_fire && (wr.addr == `OFF_CTRL);
  wire wr_cmpa  = wr_fire && (wr.addr == `OFF_CMP_A) && wr.strb[0] && wr.strb[1];
  wire wr_cmpb  = wr_fire && (wr.addr == `OFF_CMP_B) && wr.strb[0] && wr.strb[1];
  wire wr_cap   = wr_fire && (wr.addr == `OFF_CAP_TOP) && wr.strb[0] && wr.strb[1];
  wire wr_stat  = wr_fire && (wr.addr == `OFF_STATUS) && wr.strb[0];
  wire wr_cnt   = wr_fire && (wr.addr == `OFF_COUNT) && wr.strb[0] && wr.strb[1];
  wire wr_ps    = wr_fire && (wr.addr == `OFF_PRESCALE) && wr.strb[0];
  wire wr_known = wr_ctrl | wr_cmpa | wr_cmpb | wr_cap | wr_stat | wr_cnt | wr_ps;
  wire wr_mapped = (wr.addr == `OFF_CTRL) || (wr.addr == `OFF_CMP_A) || (wr.addr == `OFF_CMP_B) ||
                   (wr.addr == `OFF_CAP_TOP) || (wr.addr == `OFF_STATUS) ||
                   (wr.addr == `OFF_COUNT) || (wr.addr == `OFF_PRESCALE);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // ==========================================================
  // control registers
  logic [3:0]  mode_q;
  logic [1:0]  cma_q;
  logic [1:0]  cmb_q;
  logic        dira_q;
  logic        dirb_q;
  logic [15:0] cap_top_q;
  logic [2:0]  ps_sel_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_q    <= 4'h0;
      cma_q     <= 2'h0;
      cmb_q     <= 2'h0;
      dira_q    <= 1'b0;
      dirb_q    <= 1'b0;
      cap_top_q <= `BOTTOM;
      ps_sel_q  <= 3'h0;
    end else begin
      if (wr_ctrl && wr.strb[0]) begin
        mode_q <= wr.data[`CTRL_MODE_LSB +: 4];
        cma_q  <= wr.data[`CTRL_CMA_LSB +: 2];
        cmb_q  <= wr.data[`CTRL_CMB_LSB +: 2];
      end
      if (wr_ctrl && wr.strb[1]) begin
        dira_q <= wr.data[`CTRL_DIRA_BIT];
        dirb_q <= wr.data[`CTRL_DIRB_BIT];
      end
      if (wr_cap)
        cap_top_q <= wr.data[15:0];
      if (wr_ps)
        ps_sel_q <= wr.data[2:0];
    end
  end

  // ==========================================================
  // mode decode and top selection
  waveform_mode_t mode;
  assign mode = waveform_mode_t'(mode_q);
  wire is_pc  = (mode == WM_PC8) || (mode == WM_PC9) || (mode == WM_PC10) ||
                (mode == WM_PC_CT) || (mode == WM_PC_A);
  wire is_pfc = (mode == WM_PFC_CT) || (mode == WM_PFC_A);
  wire running = is_pc || is_pfc;
  wire top_a   = (mode == WM_PC_A) || (mode == WM_PFC_A);
  wire top_cap = (mode == WM_PC_CT) || (mode == WM_PFC_CT);

  logic [15:0] active_a;
  logic [15:0] active_b;
  logic [15:0] top;
  logic [15:0] res_mask;
  always_comb begin
    case (mode)
      WM_PC8:  top = `TOP_8BIT;
      WM_PC9:  top = `TOP_9BIT;
      WM_PC10: top = `TOP_10BIT;
      default: top = top_a ? active_a : cap_top_q;
    endcase
  end
  assign res_mask = (top_a || top_cap) ? 16'hffff : top;

  // ==========================================================
  // prescaler
  logic [9:0] pre_q;
  logic [9:0] pre_lim;
  always_comb begin
    case (ps_sel_q)
      3'h2:    pre_lim = `PS_DIV8;
      3'h3:    pre_lim = `PS_DIV64;
      3'h4:    pre_lim = `PS_DIV256;
      3'h5:    pre_lim = `PS_DIV1024;
      default: pre_lim = 10'h000;
    endcase
  end
  wire ps_on = (ps_sel_q != 3'h0) && running;
  wire tick  = ps_on && (pre_q >= pre_lim);
  always_ff @(posedge ref_clk) begin
    if (!resetn)
      pre_q <= 10'h000;
    else if (!ps_on || tick)
      pre_q <= 10'h000;
    else
      pre_q <= pre_q + 10'h001;
  end

  // ==========================================================
  // counter and direction
  logic [15:0] count_q;
  logic        down_q;
  wire at_top    = tick && (count_q == top);
  wire at_bottom = tick && (count_q == `BOTTOM);
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count_q <= `BOTTOM;
      down_q  <= 1'b0;
    end else if (wr_cnt) begin
      count_q <= wr.data[15:0];
    end else if (tick) begin
      if (at_top && !down_q)
        down_q <= 1'b1;
      else if (at_bottom && down_q)
        down_q <= 1'b0;
      // top is shown for one tick only, then the count turns straight down
      if (at_top || (down_q && !at_bottom))
        count_q <= count_q - 16'h0001;
      else
        count_q <= count_q + 16'h0001;
    end
  end

  // ==========================================================
  // compare channels
  wire load_pt = (is_pc && at_top) || (is_pfc && at_bottom);
  wire tog_ok  = top_a;
  // direction after this tick, so a match at top sets and at bottom clears
  wire dir_eff = at_top ? 1'b1 : (at_bottom ? 1'b0 : down_q);
  logic match_a;
  logic match_b;
  logic lvl_a;
  logic lvl_b;
  compare_channel u_cha (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .buf_wr    (wr_cmpa),
    .buf_wdata (wr.data[15:0]),
    .res_mask  (res_mask),
    .load      (load_pt),
    .tick      (tick),
    .count     (count_q),
    .down      (dir_eff),
    .mode      (compare_output_mode_t'(cma_q)),
    .toggle_ok (tog_ok),
    .active    (active_a),
    .match     (match_a),
    .level     (lvl_a)
  );
  compare_channel u_chb (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .buf_wr    (wr_cmpb),
    .buf_wdata (wr.data[15:0]),
    .res_mask  (res_mask),
    .load      (load_pt),
    .tick      (tick),
    .count     (count_q),
    .down      (dir_eff),
    .mode      (compare_output_mode_t'(cmb_q)),
    .toggle_ok (1'b0),
    .active    (active_b),
    .match     (match_b),
    .level     (lvl_b)
  );

  // ==========================================================
  // event flags, set wins over write-one-to-clear
  logic ovf_q;
  logic cmpa_q;
  logic cmpb_q;
  logic cap_q;
  wire clr_ovf  = wr_stat && wr.data[`ST_OVF_BIT];
  wire clr_cmpa = wr_stat && wr.data[`ST_CMPA_BIT];
  wire clr_cmpb = wr_stat && wr.data[`ST_CMPB_BIT];
  wire clr_cap  = wr_stat && wr.data[`ST_CAP_BIT];
  wire set_ovf  = running && at_bottom;
  wire set_cmpa = match_a || (at_top && top_a);
  wire set_cap  = at_top && top_cap;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ovf_q  <= 1'b0;
      cmpa_q <= 1'b0;
      cmpb_q <= 1'b0;
      cap_q  <= 1'b0;
    end else begin
      ovf_q  <= set_ovf  | (ovf_q  & ~clr_ovf);
      cmpa_q <= set_cmpa | (cmpa_q & ~clr_cmpa);
      cmpb_q <= match_b  | (cmpb_q & ~clr_cmpb);
      cap_q  <= set_cap  | (cap_q  & ~clr_cap);
    end
  end

  // ==========================================================
  // pins: pwm levels reach a pin only when connected and driven
  wire con_a = (cma_q == CM_NONINV) || (cma_q == CM_INV) || ((cma_q == CM_TOGGLE) && tog_ok);
  wire con_b = (cmb_q == CM_NONINV) || (cmb_q == CM_INV);
  pin_out_t pin_a_q;
  pin_out_t pin_b_q;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pin_a_q <= '{level: 1'b0, enable: 1'b0};
      pin_b_q <= '{level: 1'b0, enable: 1'b0};
    end else begin
      pin_a_q <= '{level: lvl_a & con_a, enable: dira_q & con_a};
      pin_b_q <= '{level: lvl_b & con_b, enable: dirb_q & con_b};
    end
  end
  assign compare_output_a    = pin_a_q.level;
  assign compare_output_a_en = pin_a_q.enable;
  assign compare_output_b    = pin_b_q.level;
  assign compare_output_b_en = pin_b_q.enable;

  // ==========================================================
  // read path
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case ({s_axi_araddr[11:2], 2'h0})
      `OFF_CTRL:     rd_mux = {22'h0, dirb_q, dira_q, cmb_q, cma_q, mode_q};
      `OFF_CMP_A:    rd_mux = {16'h0, active_a};
      `OFF_CMP_B:    rd_mux = {16'h0, active_b};
      `OFF_CAP_TOP:  rd_mux = {16'h0, cap_top_q};
      `OFF_STATUS:   rd_mux = {27'h0, down_q, cap_q, cmpb_q, cmpa_q, ovf_q};
      `OFF_COUNT:    rd_mux = {16'h0, count_q};
      `OFF_PRESCALE: rd_mux = {29'h0, ps_sel_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b0;
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule

// [pwm_load_model.sv]
// load on one compare pin: pulled low when undriven, counts high cycles and rising edges
module pwm_load_model (
  input  wire logic        ref_clk,
  input  wire logic        clr,
  input  wire logic        level,
  input  wire logic        enable,
  output logic [15:0]      high_cnt,
  output logic [15:0]      rise_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin;
  logic pin_q = 1'b0;

  // pull-down holds the undriven pin low
  assign pin = enable ? level : 1'b0;
  always @(posedge ref_clk) begin
    pin_q <= pin;
    if (clr) begin
      high_cnt <= 16'h0000;
      rise_cnt <= 16'h0000;
    end else begin
      high_cnt <= high_cnt + {15'h0000, pin};
      rise_cnt <= rise_cnt + {15'h0000, pin & ~pin_q};
    end
  end
endmodule

// [pwm_properties.sv]
// bus and pin assertions for the dual-slope pwm block
module pwm_properties (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        compare_output_a_en,
  input wire logic        compare_output_b_en
);
  logic [3:0] since_wr_q;
  logic [3:0] since_wr_d;

  // cycles since the last write response, saturating
  assign since_wr_d = s_axi_bvalid ? 4'h0 : ((since_wr_q == 4'hf) ? 4'hf : since_wr_q + 4'h1);
  always_ff @(posedge ref_clk) begin
    if (!resetn) since_wr_q <= 4'hf;
    else since_wr_q <= since_wr_d;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_enable_cause_a: assert property ($changed(compare_output_a_en) |-> since_wr_q <= 4'h4)
    else $error("pin a enable moved without a register write");
  b_enable_cause_a: assert property ($changed(compare_output_b_en) |-> since_wr_q <= 4'h4)
    else $error("pin b enable moved without a register write");
endmodule

bind dual_slope_pwm_16bit pwm_properties i_pwm_properties (
  .ref_clk(ref_clk), .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .compare_output_a_en(compare_output_a_en),
  .compare_output_b_en(compare_output_b_en));

// [tb_top.sv]
// self-checking bench for the dual-slope pwm block
`include "pwm_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_pkg::*;
  typedef struct { logic [11:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r; } row_t;
  logic ref_clk = 1'b0, resetn = 1'b0, clr = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, oa, oa_en, ob, ob_en;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  logic [15:0] hi_a, hi_b, rise_a, rise_b;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  row_t rows [6] = '{'{`OFF_CAP_TOP, 32'h1234, 32'h1234, `RESP_OKAY}, '{`OFF_COUNT, 32'h5, 32'h5, `RESP_OKAY},
    '{12'h01c, 32'hffff, 32'h0, `RESP_SLVERR}, '{`OFF_STATUS, 32'h1f, 32'h0, `RESP_OKAY},
    '{`OFF_PRESCALE, 32'h3, 32'h3, `RESP_OKAY}, '{`OFF_CTRL, 32'h3f0, 32'h3f0, `RESP_OKAY}};

  dual_slope_pwm_16bit i_dual_slope_pwm_16bit (.ref_clk(ref_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .compare_output_a(oa), .compare_output_a_en(oa_en),
    .compare_output_b(ob), .compare_output_b_en(ob_en));
  pwm_load_model i_load_a (.ref_clk(ref_clk), .clr(clr), .level(oa), .enable(oa_en),
    .high_cnt(hi_a), .rise_cnt(rise_a));
  pwm_load_model i_load_b (.ref_clk(ref_clk), .clr(clr), .level(ob), .enable(ob_en),
    .high_cnt(hi_b), .rise_cnt(rise_b));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    logic aw_got;
    logic w_got;
    logic b_got;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // readies are settled mid-cycle and hold until the next rising edge
    while (!(aw_done && w_done)) begin
      @(negedge ref_clk);
      aw_got = awvalid && (awready === 1'b1);
      w_got = wvalid && (wready === 1'b1);
      @(posedge ref_clk);
      if (aw_got) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_got) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge ref_clk);
      b_got = (bvalid === 1'b1);
      wr_resp = bresp;
      @(posedge ref_clk);
    end while (!b_got);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic got;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      got = (arready === 1'b1);
      @(posedge ref_clk);
    end while (!got);
    arvalid <= 1'b0;
    do begin
      @(negedge ref_clk);
      got = (rvalid === 1'b1);
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge ref_clk);
    end while (!got);
    rready <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    chk({28'h0, oa, oa_en, ob, ob_en}, 32'h0);
    chk({29'h0, awready, wready, arready}, 32'h7);
    @(posedge ref_clk);
    resetn <= 1'b1;
  endtask

  task automatic cfg(input waveform_mode_t m, input compare_output_mode_t ca, input compare_output_mode_t cb,
                     input logic [15:0] va, input logic [15:0] vb, input logic [2:0] ps, input logic [1:0] dir);
    wr(`OFF_PRESCALE, 32'h0);
    wr(`OFF_COUNT, 32'h0);
    wr(`OFF_CAP_TOP, 32'h10);
    wr(`OFF_CTRL, {22'h0, dir, cb, ca, m});
    wr(`OFF_CMP_A, {16'h0, va});
    wr(`OFF_CMP_B, {16'h0, vb});
    wr(`OFF_PRESCALE, {29'h0, ps});
    repeat (300) @(posedge ref_clk);
  endtask

  task automatic measure(input int w, input int ea, input int eb, input int ra);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (w) @(posedge ref_clk);
    #1;
    chk({16'h0, hi_a}, ea);
    chk({16'h0, hi_b}, eb);
    chk({16'h0, rise_a}, ra);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk({30'h0, wr_resp}, {30'h0, rows[i].r});
      rd(rows[i].a);
      chk(rd_data, rows[i].q);
      chk({30'h0, rd_resp}, {30'h0, rows[i].r});
    end
    do_reset();
    rd(`OFF_CTRL);
    chk(rd_data, 32'h0);
    cfg(WM_PC_CT, CM_NONINV, CM_INV, 16'h8, 16'h4, 3'h1, 2'b11);
    measure(128, 64, 96, 4);
    rd(`OFF_STATUS);
    chk(rd_data & 32'hf, 32'hf);
    wr(`OFF_PRESCALE, 32'h0);
    wr(`OFF_CMP_A, 32'hc);
    rd(`OFF_CMP_A);
    chk(rd_data, 32'h8);
    wr(`OFF_PRESCALE, 32'h1);
    repeat (40) @(posedge ref_clk);
    rd(`OFF_CMP_A);
    chk(rd_data, 32'hc);
    cfg(WM_PFC_CT, CM_NONINV, CM_INV, 16'h8, 16'h4, 3'h2, 2'b11);
    measure(512, 256, 384, 2);
    cfg(WM_PC_CT, CM_NONINV, CM_NONINV, 16'h8, 16'h4, 3'h1, 2'b00);
    chk({30'h0, oa_en, ob_en}, 32'h0);
    measure(128, 0, 0, 0);
    // extremes: bottom and top compare values, both polarities, both dual-slope families
    for (int k = 0; k < 8; k++) begin
      cfg(k[2] ? WM_PFC_CT : WM_PC_CT, k[1] ? CM_INV : CM_NONINV, k[1] ? CM_INV : CM_NONINV,
          k[0] ? 16'h10 : 16'h0, k[0] ? 16'h10 : 16'h0, 3'h1, 2'b11);
      measure(128, (k[0] ^ k[1]) ? 128 : 0, (k[0] ^ k[1]) ? 128 : 0, 0);
    end
    for (int k = 0; k < 2; k++) begin
      cfg(k[0] ? WM_PC_A : WM_PFC_A, CM_TOGGLE, CM_TOGGLE, 16'h10, 16'h4, 3'h1, 2'b11);
      chk({31'h0, ob_en}, 32'h0);
      wr(`OFF_STATUS, 32'hf);
      measure(128, 64, 0, 2);
      rd(`OFF_STATUS);
      chk(rd_data & 32'hf, 32'h7);
    end
    for (int k = 1; k < 4; k++) begin
      cfg(waveform_mode_t'(k), CM_NONINV, CM_NONINV, 16'hffff, 16'hffff, 3'h1, 2'b11);
      repeat (32'h1 << (k + 7)) @(posedge ref_clk);
      rd(`OFF_CMP_A);
      chk(rd_data, (32'h1 << (k + 7)) - 32'h1);
    end
    tally_and_finish();
  end
endmodule
